// ### src/gti_regs.vh
`ifndef GTI_REGS_VH
`define GTI_REGS_VH

// ------------------------------------------------------------------
// layout of the synchronised input vector
// ------------------------------------------------------------------
`define GTI_SY_W        20
`define GTI_SY_DIO_LO   0
`define GTI_SY_DIO_HI   7
`define GTI_SY_DAV      8
`define GTI_SY_NRFD     9
`define GTI_SY_NDAC     10
`define GTI_SY_ATN      11
`define GTI_SY_IFC      12
`define GTI_SY_REN      13
`define GTI_SY_EOI      14
`define GTI_SY_ADR_LO   15
`define GTI_SY_ADR_HI   19

// ------------------------------------------------------------------
// bus command bytes, seven bits, taken while attention is asserted
// ------------------------------------------------------------------
`define GTI_GRP_LISTEN  2'h1
`define GTI_GRP_TALK    2'h2
`define GTI_CMD_UNL     7'h3F
`define GTI_CMD_GTL     7'h01
`define GTI_CMD_SDC     7'h04
`define GTI_CMD_LLO     7'h11
`define GTI_CMD_DCL     7'h14
`define GTI_CMD_SPE     7'h18
`define GTI_CMD_SPD     7'h19

// ------------------------------------------------------------------
// status byte and timing
// ------------------------------------------------------------------
`define GTI_STB_RQS     6
`define GTI_CNT_W       8
`define GTI_SETTLE_DEF  4

`endif

// ### src/gti_sync.v
`timescale 1ns/100ps
`default_nettype none

module gti_sync #(
	parameter WIDTH = 1
) (
	input  wire             clk_i,
	input  wire             sys_rst_i,
	input  wire [WIDTH-1:0] async_i,
	output reg  [WIDTH-1:0] sync_o
);

	reg [WIDTH-1:0] meta;
	reg [WIDTH-1:0] s2;
	reg [WIDTH-1:0] s3;

	// ------------------------------------------------------------------
	// three stages; a bit moves only when stages two and three agree
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			// idle bus lines float high, so reset to ones
			always @(posedge clk_i or posedge sys_rst_i) begin
				if (sys_rst_i) begin
					meta[i]   <= 1'b1;
					s2[i]     <= 1'b1;
					s3[i]     <= 1'b1;
					sync_o[i] <= 1'b1;
				end else begin
					meta[i] <= async_i[i];
					s2[i]   <= meta[i];
					s3[i]   <= s2[i];
					if (s2[i] == s3[i]) begin
						sync_o[i] <= s3[i];
					end
				end
			end
		end
	endgenerate

endmodule // gti_sync

`default_nettype wire

// ### src/gti_talker_listener.v
`timescale 1ns/100ps
`default_nettype none
`include "gti_regs.vh"

// Function
// - only talker and listener; no controller lines are ever driven.
// - one full byte moves over eight data lines per handshake.
// - all handshake and management lines are active low.
// - interface clear returns talker, listener, handshakes to idle.
// - every byte under attention is accepted and decoded.
// - without attention, data moves only when addressed or in talk only.
// - remote talker/listener only while remote enable asserted.
// - end-or-identify asserted with the last talker byte.
// - service request asserted on user event until polled.
// - data driven first, data valid asserted afterwards.
// - not-ready held while a new byte cannot be taken.
// - not-accepted held until the byte is captured.
// - source waits ready before valid, accepted before removing.
// - complete source and acceptor handshakes.
// - talker with serial poll, talk only, unaddressed by listen address.
// - listener unaddressed when addressed to talk.
// - service request and remote/local with local lockout.
// - parallel poll, trigger and controller commands ignored.
// - universal and addressed device clear both honoured.
// - address from five switches, first switch most significant.
// - universal clear pulses dev_clear_o, drops a pending service request, abandons a talker byte.
module gti_talker_listener #(
	parameter SETTLE_CYCLES = `GTI_SETTLE_DEF
) (
	input  wire       clk_i,
	input  wire       sys_rst_i,
	input  wire [7:0] dio_i,
	output reg  [7:0] dio_o,
	output reg  [7:0] dio_oe_o,
	input  wire       dav_i,
	output reg        dav_o,
	output reg        dav_oe_o,
	input  wire       nrfd_i,
	output reg        nrfd_o,
	output reg        nrfd_oe_o,
	input  wire       ndac_i,
	output reg        ndac_o,
	output reg        ndac_oe_o,
	input  wire       eoi_i,
	output reg        eoi_o,
	output reg        eoi_oe_o,
	output reg        srq_o,
	output reg        srq_oe_o,
	input  wire       atn_i,
	input  wire       ifc_i,
	input  wire       ren_i,
	input  wire [4:0] addr_sw_i,
	input  wire       talk_only_i,
	input  wire [7:0] tx_data_i,
	input  wire       tx_last_i,
	input  wire       tx_valid_i,
	output reg        tx_take_o,
	output reg  [7:0] rx_data_o,
	output reg        rx_end_o,
	output reg        rx_valid_o,
	input  wire       rx_ready_i,
	input  wire       svc_req_i,
	input  wire [7:0] stb_i,
	input  wire       local_req_i,
	output reg        talker_o,
	output reg        listener_o,
	output reg        remote_o,
	output reg        lockout_o,
	output reg        spoll_o,
	output reg        srq_pend_o,
	output reg        dev_clear_o
);

	localparam AH_IDLE = 3'h0;
	localparam AH_NRDY = 3'h1;
	localparam AH_RDY  = 3'h2;
	localparam AH_ACPT = 3'h3;
	localparam AH_DONE = 3'h4;

	localparam SH_IDLE = 3'h0;
	localparam SH_SETL = 3'h1;
	localparam SH_RFD  = 3'h2;
	localparam SH_DAV  = 3'h3;
	localparam SH_END  = 3'h4;

	localparam integer          SETTLE_M1   = SETTLE_CYCLES - 1;
	localparam [`GTI_CNT_W-1:0] SETTLE_LAST = SETTLE_M1[`GTI_CNT_W-1:0];

	// ------------------------------------------------------------------
	// input synchronisation and line decoding
	// ------------------------------------------------------------------
	wire [`GTI_SY_W-1:0] sy;

	gti_sync #(
		.WIDTH (`GTI_SY_W)
	) u_sync (
		.clk_i     (clk_i),
		.sys_rst_i (sys_rst_i),
		.async_i   ({addr_sw_i, eoi_i, ren_i, ifc_i, atn_i, ndac_i, nrfd_i, dav_i, dio_i}),
		.sync_o    (sy)
	);

	// a low line is an asserted line
	wire [7:0] bus_byte = ~sy[`GTI_SY_DIO_HI:`GTI_SY_DIO_LO];
	wire       dav_a    = ~sy[`GTI_SY_DAV];
	wire       nrfd_a   = ~sy[`GTI_SY_NRFD];
	wire       ndac_a   = ~sy[`GTI_SY_NDAC];
	wire       atn_a    = ~sy[`GTI_SY_ATN];
	wire       ifc_a    = ~sy[`GTI_SY_IFC];
	wire       ren_a    = ~sy[`GTI_SY_REN];
	wire       eoi_a    = ~sy[`GTI_SY_EOI];
	wire [4:0] my_addr  = sy[`GTI_SY_ADR_HI:`GTI_SY_ADR_LO];

	wire [6:0] cmd      = bus_byte[6:0];
	wire       is_lsn   = (cmd[6:5] == `GTI_GRP_LISTEN);
	wire       is_tlk   = (cmd[6:5] == `GTI_GRP_TALK);
	wire       my_lsn   = is_lsn && (cmd[4:0] == my_addr);
	wire       my_tlk   = is_tlk && (cmd[4:0] == my_addr);

	// data phase only when addressed and remote, or in talk only
	wire lsn_act  = listener_o && ren_a && !atn_a;
	wire tlk_act  = (talker_o && ren_a || talk_only_i) && !atn_a && !ifc_a;
	wire ah_part  = (atn_a || lsn_act) && !ifc_a;

	// ------------------------------------------------------------------
	// acceptor handshake
	// ------------------------------------------------------------------
	reg [2:0] ah_st;
	reg [2:0] next_ah;

	always @* begin
		next_ah = ah_st;
		case (ah_st)
			AH_IDLE: begin
				if (ah_part) begin
					next_ah = AH_NRDY;
				end
			end
			AH_NRDY: begin
				// hold not-ready until the user can take data; under attention no wait for the user
				if (!ah_part) begin
					next_ah = AH_IDLE;
				end else if (!dav_a && (atn_a || rx_ready_i)) begin
					next_ah = AH_RDY;
				end
			end
			AH_RDY: begin
				if (!ah_part) begin
					next_ah = AH_IDLE;
				end else if (dav_a) begin
					next_ah = AH_ACPT;
				end else if (!atn_a && !rx_ready_i) begin
					// ready was granted under attention; data phase needs the user
					next_ah = AH_NRDY;
				end
			end
			AH_ACPT: begin
				next_ah = AH_DONE;
			end
			AH_DONE: begin
				if (!dav_a) begin
					next_ah = ah_part ? AH_NRDY : AH_IDLE;
				end
			end
			default: begin
				next_ah = AH_IDLE;
			end
		endcase
		if (ifc_a) begin
			next_ah = AH_IDLE;
		end
	end

	wire took      = (ah_st == AH_ACPT);
	wire took_cmd  = took && atn_a;
	wire took_data = took && !atn_a && listener_o;
	wire dcl_hit   = took_cmd && (cmd == `GTI_CMD_DCL || cmd == `GTI_CMD_SDC && listener_o);

	// ------------------------------------------------------------------
	// source handshake
	// ------------------------------------------------------------------
	reg [2:0]            sh_st;
	reg [7:0]            sh_byte;
	reg                  sh_eoi;
	reg                  sh_stb;
	reg [`GTI_CNT_W-1:0] sh_cnt;
	reg [2:0]            next_sh;
	reg [7:0]            next_sh_byte;
	reg                  next_sh_eoi;
	reg                  next_sh_stb;
	reg                  next_take;

	always @* begin
		next_sh      = sh_st;
		next_sh_byte = sh_byte;
		next_sh_eoi  = sh_eoi;
		next_sh_stb  = sh_stb;
		next_take    = 1'b0;
		case (sh_st)
			SH_IDLE: begin
				if (tlk_act && spoll_o && talker_o) begin
					next_sh_byte = {stb_i[7], srq_pend_o, stb_i[5:0]};
					next_sh_eoi  = 1'b0;
					next_sh_stb  = 1'b1;
					next_sh      = SH_SETL;
				end else if (tlk_act && tx_valid_i) begin
					next_sh_byte = tx_data_i;
					next_sh_eoi  = tx_last_i;
					next_sh_stb  = 1'b0;
					next_take    = 1'b1;
					next_sh      = SH_SETL;
				end
			end
			SH_SETL: begin
				// data lines settle before valid is raised
				if (sh_cnt == {`GTI_CNT_W{1'b0}}) begin
					next_sh = SH_RFD;
				end
			end
			SH_RFD: begin
				if (!nrfd_a) begin
					next_sh = SH_DAV;
				end
			end
			SH_DAV: begin
				if (!ndac_a) begin
					next_sh = SH_END;
				end
			end
			SH_END: begin
				next_sh = SH_IDLE;
			end
			default: begin
				next_sh = SH_IDLE;
			end
		endcase
		// attention, clear or loss of address abandons the byte
		if (!tlk_act || dcl_hit) begin
			next_sh   = SH_IDLE;
			next_take = 1'b0;
		end
	end

	wire drive_data = (next_sh == SH_SETL || next_sh == SH_RFD || next_sh == SH_DAV);
	wire stb_sent   = (sh_st == SH_END) && sh_stb;

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ah_st       <= AH_IDLE;
			sh_st       <= SH_IDLE;
			sh_byte     <= 8'h00;
			sh_eoi      <= 1'b0;
			sh_stb      <= 1'b0;
			sh_cnt      <= {`GTI_CNT_W{1'b0}};
			dio_o       <= 8'h00;
			dio_oe_o    <= 8'h00;
			dav_o       <= 1'b0;
			dav_oe_o    <= 1'b0;
			nrfd_o      <= 1'b0;
			nrfd_oe_o   <= 1'b0;
			ndac_o      <= 1'b0;
			ndac_oe_o   <= 1'b0;
			eoi_o       <= 1'b0;
			eoi_oe_o    <= 1'b0;
			srq_o       <= 1'b0;
			srq_oe_o    <= 1'b0;
			tx_take_o   <= 1'b0;
			rx_data_o   <= 8'h00;
			rx_end_o    <= 1'b0;
			rx_valid_o  <= 1'b0;
			talker_o    <= 1'b0;
			listener_o  <= 1'b0;
			remote_o    <= 1'b0;
			lockout_o   <= 1'b0;
			spoll_o     <= 1'b0;
			srq_pend_o  <= 1'b0;
			dev_clear_o <= 1'b0;
		end else begin
			ah_st     <= next_ah;
			sh_st     <= next_sh;
			sh_byte   <= next_sh_byte;
			sh_eoi    <= next_sh_eoi;
			sh_stb    <= next_sh_stb;
			tx_take_o <= next_take;
			if (sh_st == SH_IDLE) begin
				sh_cnt <= SETTLE_LAST;
			end else if (sh_cnt != {`GTI_CNT_W{1'b0}}) begin
				sh_cnt <= sh_cnt - {{(`GTI_CNT_W-1){1'b0}}, 1'b1};
			end

			// open collector: a one bit pulls its line low
			dio_oe_o  <= drive_data ? next_sh_byte : 8'h00;
			dav_oe_o  <= (next_sh == SH_DAV);
			eoi_oe_o  <= drive_data && next_sh_eoi;
			nrfd_oe_o <= (next_ah == AH_NRDY || next_ah == AH_ACPT
				|| next_ah == AH_DONE);
			ndac_oe_o <= (next_ah == AH_NRDY || next_ah == AH_RDY
				|| next_ah == AH_ACPT);

			// received data; a byte under attention is never data
			rx_valid_o <= took_data;
			if (took_data) begin
				rx_data_o <= bus_byte;
				rx_end_o  <= eoi_a;
			end

			dev_clear_o <= dcl_hit;

			// command decode; unknown commands fall through untouched
			if (took_cmd) begin
				if (my_lsn) begin
					listener_o <= 1'b1;
					talker_o   <= 1'b0;
				end else if (cmd == `GTI_CMD_UNL) begin
					listener_o <= 1'b0;
				end
				if (my_tlk) begin
					talker_o   <= 1'b1;
					listener_o <= 1'b0;
				end else if (is_tlk) begin
					talker_o <= 1'b0;
				end
				if (cmd == `GTI_CMD_SPE) begin
					spoll_o <= 1'b1;
				end
				if (cmd == `GTI_CMD_SPD) begin
					spoll_o <= 1'b0;
				end
			end
			if (ifc_a) begin
				talker_o   <= 1'b0;
				listener_o <= 1'b0;
				spoll_o    <= 1'b0;
			end

			// remote/local with lockout
			if (!ren_a) begin
				remote_o  <= 1'b0;
				lockout_o <= 1'b0;
			end else begin
				if (took_cmd && my_lsn) begin
					remote_o <= 1'b1;
				end else if (took_cmd && cmd == `GTI_CMD_GTL && listener_o) begin
					remote_o <= 1'b0;
				end else if (local_req_i && !lockout_o) begin
					remote_o <= 1'b0;
				end
				if (took_cmd && cmd == `GTI_CMD_LLO) begin
					lockout_o <= 1'b1;
				end
			end

			// service request: a new event outranks the clear
			if (svc_req_i) begin
				srq_pend_o <= 1'b1;
			end else if (stb_sent || dcl_hit) begin
				srq_pend_o <= 1'b0;
			end
			srq_oe_o <= svc_req_i || srq_pend_o && !(stb_sent || dcl_hit);
		end
	end

endmodule // gti_talker_listener

`default_nettype wire

// ### verification/gti_talker_listener_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// bus checks
// ----
module gti_talker_listener_checker (
	input wire logic       clk_i,
	input wire logic       sys_rst_i,
	input wire logic [7:0] dio_o,
	input wire logic [7:0] dio_oe_o,
	input wire logic       dav_o,
	input wire logic       srq_o,
	input wire logic       dav_i,
	input wire logic       dav_oe_o,
	input wire logic       nrfd_i,
	input wire logic       nrfd_oe_o,
	input wire logic       ndac_i,
	input wire logic       ndac_oe_o,
	input wire logic       eoi_oe_o,
	input wire logic       ifc_i,
	input wire logic       ren_i,
	input wire logic       tx_last_i,
	input wire logic       tx_take_o,
	input wire logic       rx_valid_o,
	input wire logic       svc_req_i,
	input wire logic       srq_oe_o,
	input wire logic       talker_o,
	input wire logic       listener_o,
	input wire logic       remote_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (sys_rst_i);
	sequence s_release;
		$fell(ndac_oe_o) && !dav_i;
	endsequence
	sequence s_drive;
		$rose(dav_oe_o);
	endsequence
	property p_pins;
		dio_o == 8'h00 && !dav_o && !srq_o;
	endproperty
	a_pins: assert property (p_pins) else $error("pin output not zero");
	property p_dav;
		s_drive |-> $stable(dio_oe_o) && $past(nrfd_i, 2);
	endproperty
	a_dav: assert property (p_dav) else $error("valid before data or ready");
	property p_hold;
		dav_oe_o && !ndac_i |=> dav_oe_o;
	endproperty
	a_hold: assert property (p_hold) else $error("valid dropped early");
	property p_release;
		s_release |-> nrfd_oe_o && $past(nrfd_oe_o);
	endproperty
	a_release: assert property (p_release) else $error("accept before capture");
	property p_rx;
		rx_valid_o |-> nrfd_oe_o && $past(ndac_oe_o);
	endproperty
	a_rx: assert property (p_rx) else $error("ready while byte pending");
	property p_eoi;
		$rose(eoi_oe_o) |-> tx_take_o && $past(tx_last_i);
	endproperty
	a_eoi: assert property (p_eoi) else $error("end flag on wrong byte");
	property p_ifc;
		!ifc_i |-> ##[1:8] !talker_o && !listener_o;
	endproperty
	a_ifc: assert property (p_ifc) else $error("clear left a role");
	property p_ren;
		ren_i [*8] |-> !remote_o;
	endproperty
	a_ren: assert property (p_ren) else $error("remote without enable");
	property p_srq;
		$rose(svc_req_i) |-> ##[1:2] srq_oe_o;
	endproperty
	a_srq: assert property (p_srq) else $error("service request not driven");
endmodule // gti_talker_listener_checker
`default_nettype wire

// ### verification/gti_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// bus controller
// ----
module gti_host_model (
	input  wire logic       clk_i,
	input  wire logic [7:0] dio_i,
	input  wire logic       dav_i,
	input  wire logic       nrfd_i,
	input  wire logic       ndac_i,
	input  wire logic       eoi_i,
	output var  logic [7:0] h_dio_o,
	output var  logic       h_dav_o,
	output var  logic       h_nrfd_o,
	output var  logic       h_ndac_o,
	output var  logic       h_eoi_o,
	output var  logic       h_atn_o,
	output var  logic       h_ifc_o,
	output var  logic       h_ren_o
);
	// outputs are pull-low requests; 0 lets the pull-up win
	initial {h_dio_o, h_dav_o, h_nrfd_o, h_ndac_o, h_eoi_o, h_atn_o, h_ifc_o, h_ren_o} = '0;
	task automatic send(input logic [7:0] b, input logic atn, input logic last);
		int n;
		h_atn_o = atn;
		@(negedge clk_i);
		{h_nrfd_o, h_ndac_o} = 2'h0;
		h_dio_o = b;
		h_eoi_o = last;
		repeat (6) @(negedge clk_i);
		for (n = 0; n < 99 && !nrfd_i; n++) @(negedge clk_i);
		h_dav_o = 1;
		for (n = 0; n < 99 && !ndac_i; n++) @(negedge clk_i);
		{h_dav_o, h_eoi_o, h_dio_o} = '0;
		@(negedge clk_i);
	endtask
	task automatic recv(input int d, output logic [7:0] b, output logic e);
		int n;
		{h_atn_o, h_ndac_o, h_nrfd_o} = 3'h3;
		repeat (d) @(negedge clk_i);
		h_nrfd_o = 0;
		for (n = 0; n < 99 && dav_i; n++) @(negedge clk_i);
		b = ~dio_i;
		e = !eoi_i;
		{h_nrfd_o, h_ndac_o} = 2'h2;
		for (n = 0; n < 99 && !dav_i; n++) @(negedge clk_i);
		h_ndac_o = 1;
	endtask
endmodule // gti_host_model
`default_nettype wire

// ### verification/gti_talker_listener_tb.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// bench
// ----
module gti_talker_listener_tb;
	// switches 5'h15: listen 8'h35, talk 8'h55
	localparam logic [7:0] MLA = 8'h35;
	localparam logic [7:0] MTA = 8'h55;
	logic       clk_i = 0;
	logic       sys_rst_i = 1;
	logic [4:0] addr_sw_i = 5'h15;
	logic [7:0] dio_i, dio_o, dio_oe_o, h_dio_o, tx_data_i, rx_data_o, stb_i, rxq, b;
	logic       dav_i, dav_o, dav_oe_o, nrfd_i, nrfd_o, nrfd_oe_o, ndac_i, ndac_o, ndac_oe_o;
	logic       eoi_i, eoi_o, eoi_oe_o, srq_o, srq_oe_o, atn_i, ifc_i, ren_i, talk_only_i;
	logic       tx_last_i, tx_valid_i, tx_take_o, rx_end_o, rx_valid_o, rx_ready_i, svc_req_i;
	logic       local_req_i, talker_o, listener_o, remote_o, lockout_o, spoll_o, srq_pend_o;
	logic       dev_clear_o, h_dav_o, h_nrfd_o, h_ndac_o, h_eoi_o, h_atn_o, h_ifc_o, h_ren_o;
	logic       rxe, e;
	int         err_count = 0, num_checks = 0, cyc = 0, rxn = 0, clrn = 0, n;
	// wired-AND bus
	assign dio_i = ~(dio_oe_o | h_dio_o);
	assign dav_i = ~(dav_oe_o | h_dav_o);
	assign nrfd_i = ~(nrfd_oe_o | h_nrfd_o);
	assign ndac_i = ~(ndac_oe_o | h_ndac_o);
	assign eoi_i = ~(eoi_oe_o | h_eoi_o);
	assign atn_i = ~h_atn_o;
	assign ifc_i = ~h_ifc_o;
	assign ren_i = ~h_ren_o;
	gti_talker_listener #(.SETTLE_CYCLES(2)) DUT (.*);
	gti_host_model HOST (.*);
	initial forever #2 clk_i = ~clk_i;
	always @(negedge clk_i) if (tx_take_o) tx_valid_i = 0;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (rx_valid_o) {rxq, rxe, rxn} <= {rx_data_o, rx_end_o, rxn + 1};
		if (dev_clear_o) clrn <= clrn + 1;
		if (cyc == 6000) begin
			err_count++;
			stop_test;
		end
	end
	task automatic chk8(input string s, input logic [7:0] x, input logic [7:0] g);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", s, x, g);
		end
	endtask
	task automatic chk1(input string s, input logic x, input logic g);
		chk8(s, {7'h00, x}, {7'h00, g});
	endtask
	task stop_test;
		if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task t_listen;
		HOST.h_ren_o = 1;
		HOST.send(MLA, 1, 0);
		chk1("listener", 1, listener_o);
		chk1("remote", 1, remote_o);
		HOST.send(8'hA5, 0, 1);
		chk8("rx data", 8'hA5, rxq);
		chk1("rx end", 1, rxe);
		HOST.send(8'h3F, 1, 0);
		n = rxn;
		HOST.send(8'h5A, 0, 0);
		chk8("rx count", 8'(n), 8'(rxn));
	endtask
	task t_talk;
		HOST.send(MTA, 1, 0);
		chk1("talker", 1, talker_o);
		{tx_data_i, tx_last_i, tx_valid_i} = {8'h3C, 2'h1};
		HOST.recv(0, b, e);
		chk8("byte", 8'h3C, b);
		{tx_data_i, tx_last_i, tx_valid_i} = {8'h5A, 2'h3};
		HOST.recv(5, b, e);
		chk8("last", 8'h5A, b);
		chk1("eoi", 1, e);
		HOST.send(MLA, 1, 0);
		chk1("talk off", 0, talker_o);
	endtask
	task t_poll;
		svc_req_i = 1;
		@(negedge clk_i);
		svc_req_i = 0;
		repeat (2) @(negedge clk_i);
		chk1("srq", 1, srq_oe_o);
		HOST.send(8'h18, 1, 0);
		HOST.send(MTA, 1, 0);
		chk1("listen off", 0, listener_o);
		HOST.recv(0, b, e);
		chk8("status", 8'h45, b);
		repeat (2) @(negedge clk_i);
		chk1("srq off", 0, srq_oe_o);
		HOST.send(8'h19, 1, 0);
		chk1("poll off", 0, spoll_o);
	endtask
	task t_clear;
		n = clrn;
		HOST.send(8'h14, 1, 0);
		HOST.send(8'h3F, 1, 0);
		HOST.send(8'h04, 1, 0);
		chk8("clear a", 8'(n + 1), 8'(clrn));
		HOST.send(MLA, 1, 0);
		HOST.send(8'h04, 1, 0);
		chk8("clear b", 8'(n + 2), 8'(clrn));
		HOST.h_ifc_o = 1;
		repeat (8) @(negedge clk_i);
		HOST.h_ifc_o = 0;
		chk1("ifc", 0, listener_o);
	endtask
	task t_remote;
		HOST.send(8'h11, 1, 0);
		chk1("lockout", 1, lockout_o);
		HOST.send(MLA, 1, 0);
		HOST.send(8'h01, 1, 0);
		chk1("local", 0, remote_o);
		HOST.h_ren_o = 0;
		repeat (8) @(negedge clk_i);
		chk1("ren off", 0, lockout_o);
	endtask
	task t_misc;
		HOST.h_ren_o = 1;
		HOST.send(MLA, 1, 0);
		chk1("remote on", 1, remote_o);
		local_req_i = 1;
		repeat (2) @(negedge clk_i);
		local_req_i = 0;
		chk1("local req", 0, remote_o);
		rx_ready_i = 0;
		fork
			HOST.send(8'h77, 0, 0);
			begin
				repeat (30) @(negedge clk_i);
				chk1("not ready", 0, nrfd_i);
				rx_ready_i = 1;
			end
		join
		chk8("late rx", 8'h77, rxq);
		HOST.h_ren_o = 0;
		talk_only_i = 1;
		{tx_data_i, tx_last_i, tx_valid_i} = {8'hC3, 2'h1};
		HOST.recv(0, b, e);
		talk_only_i = 0;
		chk8("talk only", 8'hC3, b);
	endtask
	initial begin
		{tx_data_i, tx_last_i, tx_valid_i, svc_req_i, local_req_i, talk_only_i} = '0;
		{rx_ready_i, stb_i} = {1'h1, 8'h05};
		repeat (5) @(negedge clk_i);
		sys_rst_i = 0;
		repeat (6) @(negedge clk_i);
		chk8("idle", 8'h00, dio_oe_o);
		t_listen;
		t_talk;
		t_poll;
		t_clear;
		t_remote;
		t_misc;
		stop_test;
	end
endmodule // gti_talker_listener_tb
bind gti_talker_listener gti_talker_listener_checker CHK (.*);
`default_nettype wire
